// ### rtl/prog_stage_defs.svh
// Offsets, field positions, reset values and timing counts of the protection stages.
// What this block does
// - Offer 10 ms task interval for short delays.
// - Offer 20 ms and 100 ms task intervals.
// - First selection is the quantity or operand one.
// - Second selection is operand two in differences.
// - Four modes: over, under, difference, absolute difference.
// - Pick-up setting is the stage limit.
// - Trip after start persists for operate delay.
// - Under mode ignores values below the floor.
// - Eight stages, each enabled or disabled.
// - Four setting groups, switched by inputs or manually.
// - Group source none, input, virtual, indicator, output.
// - Status is idle, blocked, started or tripped.
// - Start and trip counters, clearable to zero.
// - Common force flag clears after five minutes.
// - Status writable only while force flag set.
// - Editable settings need password unlock first.
// - Record eight latest faults with stamp, value, group.
// - Elapsed delay in percent, 100 means trip.
`ifndef PROG_STAGE_DEFS_SVH
`define PROG_STAGE_DEFS_SVH
`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define FORCE_TIMEOUT_MIN 5
`define FORCE_TIMEOUT_MS (`FORCE_TIMEOUT_MIN * 60 * 1000)
`define TASK_10_MS 7'h0a
`define TASK_20_MS 7'h14
`define TASK_100_MS 7'h64
`define TRIP_PCT 7'h64
`define ADDR_CTRL 12'h000
`define ADDR_KEY 12'h004
`define ADDR_GROUP 12'h008
`define ADDR_FLT_SEL 12'h00c
`define ADDR_FLT_TSL 12'h010
`define ADDR_FLT_TSH 12'h014
`define ADDR_FLT_INF 12'h018
`define STG_BASE 12'h100
`define STG_END 12'h300
`define OFS_CFG 6'h00
`define OFS_DELAY 6'h04
`define OFS_HYST 6'h08
`define OFS_STAT 6'h0c
`define OFS_SCNT 6'h10
`define OFS_TCNT 6'h14
`define OFS_PICK0 6'h20
`define OFS_PICK3 6'h2c
`define CTRL_FORCE 0
`define CTRL_UNLOCK 1
`define CFG_EN 0
`define GRP_ACT_LSB 16
`define FLT_PCT_LSB 17
`define FLT_GRP_LSB 24
`define FLT_STG_LSB 26
`define DELAY_RST 16'h0064
`define HYST_RST 7'h03
`endif

// ### rtl/prog_stage_pkg.sv
// Types shared by the protection stage files.
package prog_stage_pkg;
  typedef enum logic [1:0] {
    CMP_OVER = 2'h0,
    CMP_UNDER = 2'h1,
    CMP_DIFF = 2'h2,
    CMP_ABS_DIFF = 2'h3
  } comparison_selector_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STARTED = 2'h1,
    ST_TRIPPED = 2'h3,
    ST_BLOCKED = 2'h2
  } stage_status_e;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_DIGITAL = 3'h1,
    SRC_VIRTUAL_IN = 3'h2,
    SRC_INDICATOR = 3'h3,
    SRC_VIRTUAL_OUT = 3'h4
  } group_switch_source_e;
  typedef struct packed {
    logic en;
    comparison_selector_e mode;
    logic [1:0] tint;
    logic [3:0] sel_a;
    logic [3:0] sel_b;
    logic [15:0] delay_ms;
    logic [6:0] hyst;
    logic [15:0] under_mode_floor;
    logic [3:0][15:0] pick;
    stage_status_e status;
    logic [15:0] elapsed;
    logic [6:0] tick;
    logic [16:0] peak;
    logic [15:0] start_event_tally;
    logic [15:0] trip_event_tally;
  } stage_s;
  typedef struct packed {
    logic [47:0] stamp;
    logic [16:0] value;
    logic [6:0] elapsed_delay_pct;
    logic [1:0] group;
    logic [2:0] stage;
  } fault_s;
endpackage

// ### rtl/fault_rec_if.sv
// Write and read port bundle between the stage logic and the fault record memory.
`timescale 1ns/1ps
interface fault_rec_if #(parameter int AW = 3);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  prog_stage_pkg::fault_s wr_data;
  logic [AW-1:0] rd_addr;
  prog_stage_pkg::fault_s rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// ### rtl/fault_rec_mem.sv
// Small memory holding the most recent fault records, with registered read data.
`timescale 1ns/1ps
module fault_rec_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic ce_in,
  fault_rec_if.mem port
);
  prog_stage_pkg::fault_s mem [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_chk
    $error("fault_rec_mem: DEPTH must equal 2**AW");
  end

  // No reset on the array; unwritten entries are never shown as valid faults by software.
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (port.wr_en) begin
        mem[port.wr_addr] <= port.wr_data;
      end
      port.rd_data <= mem[port.rd_addr];
    end
  end
endmodule

// ### rtl/programmable_protection_stage.sv
// Eight programmable protection stages with setting groups, force flag and fault record.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "prog_stage_defs.svh"
module programmable_protection_stage #(
  parameter int N_SIG = 16,
  parameter int N_STAGE = 8,
  parameter int CYCLES_PER_MS = `MS_CYCLES,
  parameter int FORCE_MS = `FORCE_TIMEOUT_MS,
  parameter logic [31:0] UNLOCK_KEY = 32'h5a5a0001 // Arbitrary value.
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [N_SIG*16-1:0] meas_in,
  input wire logic [N_STAGE-1:0] block_in,
  input wire logic [15:0] digital_input_n_in,
  input wire logic [15:0] virtual_input_n_in,
  input wire logic [15:0] indicator_signal_n_in,
  input wire logic [15:0] virtual_output_n_in,
  input wire logic [47:0] timestamp_in,
  output logic [N_STAGE-1:0] start_out,
  output logic [N_STAGE-1:0] trip_out,
  output logic [1:0] active_group_out
);
  if (N_SIG < 2 || N_SIG > 16 || N_STAGE < 1 || N_STAGE > 8 ||
      CYCLES_PER_MS < 1 || CYCLES_PER_MS > 32767 ||
      FORCE_MS < 1 || FORCE_MS > 524287) begin : g_chk
    $error("programmable_protection_stage: parameter out of range");
  end

  typedef struct packed {
    prog_stage_pkg::stage_s [N_STAGE-1:0] stg;
    logic force_on;
    logic [18:0] force_ms;
    logic unlocked;
    logic [1:0] grp_manual;
    logic [1:0] grp_alt;
    prog_stage_pkg::group_switch_source_e grp_src;
    logic [3:0] grp_idx;
    logic [1:0] grp_act;
    logic [2:0] flt_sel;
    logic [2:0] wptr;
    logic [14:0] ms_div;
    logic [31:0] prdata;
  } state_s;

  state_s s_reg;
  state_s s_next;
  fault_rec_if #(.AW(3)) rec ();

  fault_rec_mem #(.DEPTH(8), .AW(3)) u_mem (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .port(rec.mem)
  );

  // Task interval code to milliseconds; the unused code falls back to the slowest rate.
  function automatic logic [6:0] task_ms(input logic [1:0] code);
    case (code)
      2'h0: task_ms = `TASK_10_MS;
      2'h1: task_ms = `TASK_20_MS;
      default: task_ms = `TASK_100_MS;
    endcase
  endfunction

  // One measured channel, sign-extended so that differences cannot overflow.
  function automatic logic signed [16:0] chan(input logic [N_SIG*16-1:0] m,
                                              input logic [3:0] idx);
    logic [15:0] w;
    w = m[16*idx +: 16];
    chan = $signed({w[15], w});
  endfunction

  // Dead band as a share of the pick-up magnitude.
  function automatic logic signed [16:0] dead_band(input logic signed [16:0] pk,
                                                   input logic [6:0] pct);
    logic [23:0] mag;
    mag = 24'(pk < 0 ? -pk : pk) * 24'(pct);
    dead_band = $signed(17'(mag / 24'd100));
  endfunction

  // Software-facing view of a register, shared by the read path.
  function automatic logic [31:0] read_mux(input state_s st, input logic [11:0] a,
                                           input prog_stage_pkg::fault_s f);
    logic [11:0] r;
    logic [2:0] i;
    r = a - `STG_BASE;
    i = r[8:6];
    read_mux = '0;
    if (a >= `STG_BASE && a < `STG_END) begin
      case (r[5:0])
        `OFS_CFG: read_mux = {12'h0, st.stg[i].sel_b, 4'h0, st.stg[i].sel_a, 3'h0,
                              st.stg[i].tint, st.stg[i].mode, st.stg[i].en};
        `OFS_DELAY: read_mux = {16'h0, st.stg[i].delay_ms};
        `OFS_HYST: read_mux = {st.stg[i].under_mode_floor, 9'h0, st.stg[i].hyst};
        `OFS_STAT: read_mux = {st.stg[i].elapsed, 14'h0, st.stg[i].status};
        `OFS_SCNT: read_mux = {16'h0, st.stg[i].start_event_tally};
        `OFS_TCNT: read_mux = {16'h0, st.stg[i].trip_event_tally};
        default: read_mux = (r[5:4] == 2'h2) ? {16'h0, st.stg[i].pick[r[3:2]]} : '0;
      endcase
    end else begin
      case (a)
        `ADDR_CTRL: read_mux = {30'h0, st.unlocked, st.force_on};
        `ADDR_GROUP: read_mux = {14'h0, st.grp_act, 4'h0, st.grp_idx, 1'b0, st.grp_src,
                                 st.grp_alt, st.grp_manual};
        `ADDR_FLT_SEL: read_mux = {29'h0, st.flt_sel};
        `ADDR_FLT_TSL: read_mux = f.stamp[31:0];
        `ADDR_FLT_TSH: read_mux = {16'h0, f.stamp[47:32]};
        `ADDR_FLT_INF: read_mux = {3'h0, f.stage, f.group, f.elapsed_delay_pct, f.value};
        default: read_mux = '0;
      endcase
    end
  endfunction

  // Access check: unmapped, locked setting, or status write without force.
  function automatic logic bad_access(input state_s st, input logic [11:0] a,
                                      input logic wr);
    logic [11:0] r;
    r = a - `STG_BASE;
    bad_access = 1'b0;
    if (a >= `STG_BASE && a < `STG_END) begin
      if (r[5:0] == `OFS_STAT) begin
        bad_access = wr && !st.force_on;
      end else if (r[5:0] == `OFS_SCNT || r[5:0] == `OFS_TCNT) begin
        bad_access = 1'b0;
      end else if (r[5:0] <= `OFS_HYST || (r[5:0] >= `OFS_PICK0 && r[5:0] <= `OFS_PICK3)) begin
        bad_access = wr && !st.unlocked;
      end else begin
        bad_access = 1'b1;
      end
    end else begin
      case (a)
        `ADDR_CTRL, `ADDR_GROUP: bad_access = wr && !st.unlocked;
        `ADDR_KEY: bad_access = !wr;
        `ADDR_FLT_SEL: bad_access = 1'b0;
        `ADDR_FLT_TSL, `ADDR_FLT_TSH, `ADDR_FLT_INF: bad_access = wr;
        default: bad_access = 1'b1;
      endcase
    end
  endfunction

  logic ms_tick;
  logic src_bit;
  logic [N_STAGE-1:0] sev;
  logic [N_STAGE-1:0] tev;
  logic rec_v;
  prog_stage_pkg::fault_s rec_d;
  logic wr_ok;

  // Whole next-state computation: time base, force, groups, stages, then bus writes.
  always_comb begin
    logic signed [16:0] a;
    logic signed [16:0] b;
    logic signed [16:0] q;
    logic signed [16:0] pk;
    logic signed [16:0] db;
    logic signed [16:0] fl;
    logic pick_up;
    logic hold;
    logic [16:0] el;
    logic [6:0] ti;
    logic [11:0] r;
    logic [2:0] si;
    logic [23:0] pct;
    s_next = s_reg;
    a = '0;
    b = '0;
    q = '0;
    pk = '0;
    db = '0;
    fl = '0;
    pick_up = 1'b0;
    hold = 1'b0;
    el = '0;
    ti = '0;
    pct = '0;
    sev = '0;
    tev = '0;
    rec_v = 1'b0;
    rec_d = '0;
    r = paddr_in - `STG_BASE;
    si = r[8:6];
    ms_tick = (s_reg.ms_div == 15'(CYCLES_PER_MS - 1));
    s_next.ms_div = ms_tick ? '0 : s_reg.ms_div + 15'h0001;
    // The force flag times out on its own so a forgotten test cannot latch outputs.
    if (s_reg.force_on && ms_tick) begin
      if (s_reg.force_ms == 19'(FORCE_MS - 1)) begin
        s_next.force_on = 1'b0;
        s_next.force_ms = '0;
      end else begin
        s_next.force_ms = s_reg.force_ms + 19'h00001;
      end
    end
    // A selected signal that is high switches to the alternate group.
    case (s_reg.grp_src)
      prog_stage_pkg::SRC_DIGITAL: src_bit = digital_input_n_in[s_reg.grp_idx];
      prog_stage_pkg::SRC_VIRTUAL_IN: src_bit = virtual_input_n_in[s_reg.grp_idx];
      prog_stage_pkg::SRC_INDICATOR: src_bit = indicator_signal_n_in[s_reg.grp_idx];
      prog_stage_pkg::SRC_VIRTUAL_OUT: src_bit = virtual_output_n_in[s_reg.grp_idx];
      default: src_bit = 1'b0;
    endcase
    s_next.grp_act = src_bit ? s_reg.grp_alt : s_reg.grp_manual;
    // Blocking and disabling act every cycle; comparisons run only at each stage's own task interval.
    for (int i = 0; i < N_STAGE; i++) begin
      ti = task_ms(s_reg.stg[i].tint);
      a = chan(meas_in, s_reg.stg[i].sel_a);
      b = chan(meas_in, s_reg.stg[i].sel_b);
      pk = $signed({s_reg.stg[i].pick[s_reg.grp_act][15],
                    s_reg.stg[i].pick[s_reg.grp_act]});
      db = dead_band(pk, s_reg.stg[i].hyst);
      fl = $signed({s_reg.stg[i].under_mode_floor[15], s_reg.stg[i].under_mode_floor});
      case (s_reg.stg[i].mode)
        prog_stage_pkg::CMP_DIFF: q = a - b;
        prog_stage_pkg::CMP_ABS_DIFF: q = (a - b < 0) ? b - a : a - b;
        default: q = a;
      endcase
      if (s_reg.stg[i].mode == prog_stage_pkg::CMP_UNDER) begin
        pick_up = (q < pk) && (q >= fl);
        hold = (q < pk + db) && (q >= fl);
      end else begin
        pick_up = q > pk;
        hold = q > pk - db;
      end
      el = 17'(s_reg.stg[i].elapsed) + 17'(ti);
      if (block_in[i]) begin
        s_next.stg[i].status = prog_stage_pkg::ST_BLOCKED;
        s_next.stg[i].elapsed = '0;
      end else if (!s_reg.stg[i].en) begin
        s_next.stg[i].status = prog_stage_pkg::ST_IDLE;
        s_next.stg[i].elapsed = '0;
        s_next.stg[i].tick = '0;
      end else if (ms_tick) begin
        s_next.stg[i].tick = s_reg.stg[i].tick + 7'h01;
        if (s_reg.stg[i].tick + 7'h01 >= ti) begin
          s_next.stg[i].tick = '0;
          unique case (s_reg.stg[i].status)
            prog_stage_pkg::ST_IDLE, prog_stage_pkg::ST_BLOCKED: begin
              s_next.stg[i].status = pick_up ? prog_stage_pkg::ST_STARTED
                                             : prog_stage_pkg::ST_IDLE;
              s_next.stg[i].elapsed = '0;
              s_next.stg[i].peak = q;
              sev[i] = pick_up;
            end
            prog_stage_pkg::ST_STARTED: begin
              if (!hold) begin
                s_next.stg[i].status = prog_stage_pkg::ST_IDLE;
                s_next.stg[i].elapsed = '0;
              end else begin
                s_next.stg[i].elapsed = el[16] ? 16'hffff : el[15:0];
                if (s_reg.stg[i].mode == prog_stage_pkg::CMP_UNDER ? $signed(q) <
                    $signed(s_reg.stg[i].peak) : $signed(q) > $signed(s_reg.stg[i].peak)) begin
                  s_next.stg[i].peak = q;
                end
                if (el >= 17'(s_reg.stg[i].delay_ms)) begin
                  s_next.stg[i].status = prog_stage_pkg::ST_TRIPPED;
                  tev[i] = 1'b1;
                end
              end
              // Lower stage numbers win when two stages end a fault together.
              if ((!hold || el >= 17'(s_reg.stg[i].delay_ms)) && !rec_v) begin
                rec_v = 1'b1;
                pct = (hold || s_reg.stg[i].delay_ms == '0) ? 24'(`TRIP_PCT) :
                      (24'(s_reg.stg[i].elapsed) * 24'd100) / 24'(s_reg.stg[i].delay_ms);
                rec_d.elapsed_delay_pct = (pct > 24'(`TRIP_PCT)) ? `TRIP_PCT
                                                                 : pct[6:0];
                rec_d.stamp = timestamp_in;
                rec_d.value = s_reg.stg[i].peak;
                rec_d.group = s_reg.grp_act;
                rec_d.stage = 3'(i);
              end
            end
            prog_stage_pkg::ST_TRIPPED: begin
              if (!hold) begin
                s_next.stg[i].status = prog_stage_pkg::ST_IDLE;
                s_next.stg[i].elapsed = '0;
              end
            end
          endcase
        end
      end
      s_next.stg[i].start_event_tally = s_reg.stg[i].start_event_tally + 16'(sev[i]);
      s_next.stg[i].trip_event_tally = s_reg.stg[i].trip_event_tally + 16'(tev[i]);
    end
    if (rec_v) begin
      s_next.wptr = s_reg.wptr + 3'h1;
    end
    // Read data is captured in the setup cycle so the access phase needs no wait.
    if (psel_in && !penable_in) begin
      s_next.prdata = read_mux(s_reg, paddr_in, rec.rd_data);
    end
    wr_ok = psel_in && penable_in && pwrite_in && !bad_access(s_reg, paddr_in, 1'b1);
    if (wr_ok && paddr_in >= `STG_BASE && paddr_in < `STG_END) begin
      case (r[5:0])
        `OFS_CFG: begin
          s_next.stg[si].en = pwdata_in[`CFG_EN];
          s_next.stg[si].mode = prog_stage_pkg::comparison_selector_e'(pwdata_in[2:1]);
          s_next.stg[si].tint = pwdata_in[4:3];
          s_next.stg[si].sel_a = pwdata_in[11:8];
          s_next.stg[si].sel_b = pwdata_in[19:16];
        end
        `OFS_DELAY: s_next.stg[si].delay_ms = pwdata_in[15:0];
        `OFS_HYST: begin
          s_next.stg[si].hyst = pwdata_in[6:0];
          s_next.stg[si].under_mode_floor = pwdata_in[31:16];
        end
        `OFS_STAT: begin
          s_next.stg[si].status =
            prog_stage_pkg::stage_status_e'(pwdata_in[1:0]);
        end
        // A counter event in the clearing cycle survives as a count of one.
        `OFS_SCNT: s_next.stg[si].start_event_tally = 16'(sev[si]);
        `OFS_TCNT: s_next.stg[si].trip_event_tally = 16'(tev[si]);
        default: s_next.stg[si].pick[r[3:2]] = pwdata_in[15:0];
      endcase
    end else if (wr_ok) begin
      case (paddr_in)
        `ADDR_CTRL: begin
          s_next.force_on = pwdata_in[`CTRL_FORCE];
          s_next.force_ms = '0;
        end
        `ADDR_KEY: s_next.unlocked = (pwdata_in == UNLOCK_KEY);
        `ADDR_GROUP: begin
          s_next.grp_manual = pwdata_in[1:0];
          s_next.grp_alt = pwdata_in[3:2];
          s_next.grp_src = prog_stage_pkg::group_switch_source_e'(pwdata_in[6:4]);
          s_next.grp_idx = pwdata_in[11:8];
        end
        `ADDR_FLT_SEL: s_next.flt_sel = pwdata_in[2:0];
        default: s_next.flt_sel = s_reg.flt_sel;
      endcase
    end
  end

  // Fault record port: newest entry is selection zero.
  assign rec.wr_en = rec_v && ce_in;
  assign rec.wr_addr = s_reg.wptr;
  assign rec.wr_data = rec_d;
  assign rec.rd_addr = s_reg.wptr - 3'h1 - s_reg.flt_sel;

  // Single state register; the clock enable freezes everything including the bus.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      for (int i = 0; i < N_STAGE; i++) begin
        s_reg.stg[i].delay_ms <= `DELAY_RST;
        s_reg.stg[i].hyst <= `HYST_RST;
        s_reg.stg[i].sel_b <= 4'h1;
      end
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  // Bus answers in the first access cycle unless the clock enable is low.
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && bad_access(s_reg, paddr_in, pwrite_in);
  assign prdata_out = s_reg.prdata;
  assign active_group_out = s_reg.grp_act;

  // Start is shown while started or tripped, trip only while tripped.
  always_comb begin
    for (int i = 0; i < N_STAGE; i++) begin
      start_out[i] = s_reg.stg[i].status[0];
      trip_out[i] = s_reg.stg[i].status == prog_stage_pkg::ST_TRIPPED;
    end
  end
endmodule

// ### test/prog_stage_props.sv
// Checker of the protection stage port behaviour.
`timescale 1ns/1ps
`include "prog_stage_defs.svh"
module prog_stage_props #(
  parameter int N_STAGE = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input logic pready_out,
  input logic pslverr_out,
  input wire logic [N_STAGE-1:0] block_in,
  input logic [N_STAGE-1:0] start_out,
  input logic [N_STAGE-1:0] trip_out,
  input logic [1:0] active_group_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // A tripped stage is always a started stage.
  a_trip_needs_start: assert property ((trip_out & ~start_out) == '0)
    else $error("trip seen without start");
  // Trip never rises unless start was shown the cycle before, or software wrote a register.
  a_trip_after_start: assert property (!$past(psel_in && penable_in && pwrite_in) |->
    (trip_out & ~$past(trip_out) & ~$past(start_out)) == '0) else $error("trip came early");
  a_reset_quiet: assert property ($rose(rst_n_in) |->
    start_out == '0 && trip_out == '0 && active_group_out == 2'h0) else $error("reset state");
  a_ready_follows_ce: assert property (pready_out == ce_in) else $error("pready wrong");
  a_err_in_access: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("pslverr outside access");
  a_key_unreadable: assert property (psel_in && penable_in && !pwrite_in &&
    paddr_in == `ADDR_KEY |-> pslverr_out) else $error("key read accepted");
  a_unmapped_err: assert property (psel_in && penable_in && paddr_in >= `STG_END |->
    pslverr_out) else $error("unmapped access accepted");
  // Blocking wins one cycle later, since status is registered.
  a_block_stops_start: assert property (!$past(psel_in && penable_in && pwrite_in) |->
    (start_out & $past(block_in) & {N_STAGE{$past(ce_in)}}) == '0) else $error("blocked start");
endmodule
bind programmable_protection_stage prog_stage_props #(.N_STAGE(N_STAGE)) u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .block_in(block_in),
  .start_out(start_out), .trip_out(trip_out), .active_group_out(active_group_out));

// ### test/meas_model.sv
// Far-side model of the measurement channels and the group selector lines.
`timescale 1ns/1ps
module meas_model (
  input wire logic clk_in,
  input wire logic [2:0][15:0] chan_in,
  input wire logic [2:0] src_in,
  input wire logic lvl_in,
  output logic [255:0] meas_out,
  output logic [15:0] dig_out,
  output logic [15:0] vin_out,
  output logic [15:0] ind_out,
  output logic [15:0] vout_out
);
  logic [15:0] noise_reg = 16'h0;
  // Unused channels wander, so a wrong channel select cannot pass by luck.
  always_ff @(posedge clk_in) begin
    noise_reg <= noise_reg + 16'h1357;
  end
  assign meas_out = {{13{noise_reg}}, chan_in[2], chan_in[1], chan_in[0]};
  // Only the selected source carries the level; the others carry its inverse, or all ones when the source is none.
  assign dig_out = (src_in == 3'h1) ? {16{lvl_in}} : {16{~lvl_in | (src_in == 3'h0)}};
  assign vin_out = (src_in == 3'h2) ? {16{lvl_in}} : {16{~lvl_in | (src_in == 3'h0)}};
  assign ind_out = (src_in == 3'h3) ? {16{lvl_in}} : {16{~lvl_in | (src_in == 3'h0)}};
  assign vout_out = (src_in == 3'h4) ? {16{lvl_in}} : {16{~lvl_in | (src_in == 3'h0)}};
endmodule

// ### test/tb.sv
// Bench driving the stages over APB against a measurement model.
`timescale 1ns/1ps
`include "prog_stage_defs.svh"
module tb;
  localparam logic [31:0] KEY = 32'h0000a5c3; // Arbitrary value.
  logic clk = 0, rst_n = 0, ce = 1, psel = 0, pen = 0, pwr = 0, e, lvl = 0, rdy, err;
  logic [11:0] pa = 12'h0;
  logic [31:0] pd = 32'h0, prd, rd;
  logic [255:0] meas;
  logic [7:0] blk = 8'h0, st, tr;
  logic [15:0] dig, vin, ind, vout;
  logic [2:0][15:0] chv = '0;
  logic [2:0] src = 3'h0;
  logic [1:0] grp;
  logic [1:0] md [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [15:0] va [6] = '{16'h32, 16'h1e, 16'h5, 16'h50, 16'h14, 16'h14};
  logic [15:0] vb [6] = '{16'h0, 16'h0, 16'h0, 16'h14, 16'h50, 16'h50};
  logic ex [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int error_cnt = 0, tests_run = 0;
  programmable_protection_stage #(.CYCLES_PER_MS(4), .FORCE_MS(20), .UNLOCK_KEY(KEY)) DUT (
    .clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(err), .meas_in(meas), .block_in(blk), .digital_input_n_in(dig),
    .virtual_input_n_in(vin), .indicator_signal_n_in(ind), .virtual_output_n_in(vout),
    .timestamp_in(48'h1234_5678), .start_out(st), .trip_out(tr), .active_group_out(grp));
  meas_model u_model (.clk_in(clk), .chan_in(chv), .src_in(src), .lvl_in(lvl),
    .meas_out(meas), .dig_out(dig), .vin_out(vin), .ind_out(ind), .vout_out(vout));
  // Clock at 20 MHz.
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the leading edge keeps back-to-back calls from colliding.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [11:0] sa(input logic [2:0] s, input logic [5:0] o);
    return `STG_BASE + {3'h0, s, o};
  endfunction
  // Waits, bounded, for stage zero's start or trip to reach a level.
  task automatic await(input logic t, input logic v);
    int n;
    n = 0;
    while ((t ? tr[0] : st[0]) !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 32'(t ? tr[0] : st[0]), 32'(v));
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b1, `ADDR_CTRL, 32'h1);
    chk("locked", 32'(e), 32'h1);
    xfer(1'b0, `ADDR_KEY, 32'h0);
    chk("keyread", 32'(e), 32'h1);
    xfer(1'b0, `STG_END, 32'h0);
    chk("unmapped", 32'(e), 32'h1);
    xfer(1'b0, sa(3'h3, `OFS_CFG), 32'h0);
    chk("cfgrst", rd, 32'h10000);
    xfer(1'b1, `ADDR_KEY, KEY);
    xfer(1'b1, sa(3'h0, `OFS_STAT), 32'h1);
    chk("statwr", 32'(e), 32'h1);
    xfer(1'b1, `ADDR_CTRL, 32'h1);
    xfer(1'b1, sa(3'h2, `OFS_STAT), 32'h3);
    chk("forcedwr", 32'(e), 32'h0);
    repeat (60) @(posedge clk);
    xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("force", rd, 32'h3);
    repeat (40) @(posedge clk);
    xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("forceoff", rd, 32'h2);
    for (int k = 0; k < 5; k++) begin
      src <= 3'(k);
      lvl <= 1'b1;
      xfer(1'b1, `ADDR_GROUP, 32'h309 | 32'(k << 4));
      repeat (3) @(posedge clk);
      chk("group", 32'(grp), (k != 0) ? 32'h2 : 32'h1);
    end
    lvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk("groupman", 32'(grp), 32'h1);
    xfer(1'b1, `ADDR_GROUP, 32'h0);
    xfer(1'b1, sa(3'h1, `OFS_HYST), 32'h000a0003);
    xfer(1'b1, sa(3'h1, `OFS_PICK0), 32'h28);
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, sa(3'h1, `OFS_CFG), 32'h0);
      chv[1] <= va[k];
      chv[2] <= vb[k];
      xfer(1'b1, sa(3'h1, `OFS_CFG), {12'h0, 4'h2, 4'h0, 4'h1, 5'h0, md[k], 1'b1});
      repeat (100) @(posedge clk);
      chk("mode", 32'(st[1]), 32'(ex[k]));
    end
    xfer(1'b1, sa(3'h1, `OFS_CFG), 32'h0);
    repeat (3) @(posedge clk);
    chk("disabled", 32'(st[1]), 32'h0);
    chv[1] <= 16'h32;
    xfer(1'b1, sa(3'h1, `OFS_CFG), 32'h109);
    repeat (60) @(posedge clk);
    chk("task20early", 32'(st[1]), 32'h0);
    repeat (40) @(posedge clk);
    chk("task20", 32'(st[1]), 32'h1);
    xfer(1'b1, sa(3'h0, `OFS_PICK0), 32'h64);
    xfer(1'b1, sa(3'h0, `OFS_DELAY), 32'h14);
    chv[0] <= 16'hc8;
    xfer(1'b1, sa(3'h0, `OFS_CFG), 32'h1);
    await(1'b0, 1'b1);
    repeat (60) @(posedge clk);
    chk("early", 32'(tr[0]), 32'h0);
    await(1'b1, 1'b1);
    xfer(1'b1, `ADDR_FLT_SEL, 32'h0);
    repeat (2) @(posedge clk);
    xfer(1'b0, `ADDR_FLT_INF, 32'h0);
    chk("fault", rd, {6'h0, 2'h0, 7'h64, 17'hc8});
    xfer(1'b0, `ADDR_FLT_TSL, 32'h0);
    chk("stamp", rd, 32'h12345678);
    xfer(1'b0, sa(3'h0, `OFS_SCNT), 32'h0);
    chk("starts", rd, 32'h1);
    xfer(1'b1, sa(3'h0, `OFS_TCNT), 32'h0);
    xfer(1'b0, sa(3'h0, `OFS_TCNT), 32'h0);
    chk("tripclr", rd, 32'h0);
    chv[0] <= 16'h62;
    repeat (100) @(posedge clk);
    chk("deadband", 32'(st[0]), 32'h1);
    chv[0] <= 16'h61;
    await(1'b0, 1'b0);
    chv[0] <= 16'hc8;
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    chk("frozen", 32'(st[0]), 32'h0);
    ce <= 1'b1;
    blk <= 8'h01;
    repeat (100) @(posedge clk);
    xfer(1'b0, sa(3'h0, `OFS_STAT), 32'h0);
    chk("blocked", {30'h0, rd[1:0]}, 32'h2);
    give_verdict;
  end
  // Watchdog well beyond the expected run of about fourteen hundred cycles.
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
endmodule
